//--- bench/data_space_map_chk.sv
// port assertions for the data-space map
module data_space_map_chk
  import dspace_pkg::*;
(
  input wire logic ref_clk, rst, ds_rd, ds_wr, bit_op, // controls
  input wire logic [7:0] ds_addr, ds_wdata, ds_rdata, prog_data, // bus
  input wire logic [7:0] accumulator_reg, index_pointer_first, // core
  input wire logic [7:0] ram_page_select, // page select
  input wire logic [6:0] rom_window_page, // window page
  input wire logic ds_rvalid, // read valid
  input wire logic page_one_en, page_two_en // page enables
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_acc; ds_rd && ds_addr == ACC_ADDR
    |=> ds_rdata == $past(accumulator_reg); endproperty
  a_acc: assert property (p_acc) else $error("acc read");
  property p_rv; ds_rd |=> ds_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("read valid");
  property p_ptr; ds_wr && ds_addr == PTR_FIRST_ADDR
    |=> index_pointer_first == $past(ds_wdata); endproperty
  a_ptr: assert property (p_ptr) else $error("pointer");
  property p_win; ds_wr && !bit_op && ds_addr == WIN_PAGE_ADDR
    |=> rom_window_page == $past(ds_wdata[6:0]); endproperty
  a_win: assert property (p_win) else $error("window page");
  property p_bit; ds_wr && bit_op && ds_addr == PAGE_SEL_ADDR
    |=> $stable(ram_page_select); endproperty
  a_bit: assert property (p_bit) else $error("bit op");
  property p_one; ram_page_select == 8'h08
    |=> page_one_en && !page_two_en; endproperty
  a_one: assert property (p_one) else $error("page one");
  property p_two; ram_page_select == 8'h10
    |=> page_two_en && !page_one_en; endproperty
  a_two: assert property (p_two) else $error("page two");
  property p_rom; ds_rd && ds_addr inside {[WIN_LO:WIN_HI]}
    |=> ds_rdata == $past(prog_data); endproperty
  a_rom: assert property (p_rom) else $error("rom read");
  property p_wo; ds_rd && ds_addr == WIN_PAGE_ADDR
    |=> ds_rdata == WRITE_ONLY_READ && $stable(rom_window_page);
  endproperty
  a_wo: assert property (p_wo) else $error("wo read");
endmodule

//--- bench/data_space_map_tb.sv
// self-checking bench for the data-space map
module data_space_map_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dspace_pkg::*;
  logic ref_clk = 0, rst = 1, ds_rd = 0, ds_wr = 0, bit_op = 0;
  logic [7:0] ds_addr = 0, ds_wdata = 0, ds_rdata, prog_data, r, k;
  logic [7:0] accumulator_reg, index_pointer_first, index_pointer_second;
  logic [7:0] short_direct_first, short_direct_second, ram_page_select;
  logic [12:0] prog_addr;
  logic [6:0] rom_window_page;
  logic ds_rvalid, bank0_en, page_one_en, page_two_en;
  logic [7:0] sv [3] = '{8'h08, 8'h10, 8'h00};
  logic [7:0] ra [5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hFF};
  int bad_count = 0, tests_run = 0;
  data_space_map data_space_map_i (.*);
  prog_mem_model prog_mem_model_i (.*);
  always #25 ref_clk = ~ref_clk;
  function automatic logic [7:0] pm(logic [12:0] a);
    return a[7:0] ^ {3'h0, a[12:8]};
  endfunction
  task automatic chk(string n, logic [7:0] s, e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, d, logic b);
    @(negedge ref_clk);
    {ds_addr, ds_wdata, bit_op, ds_wr} = {a, d, b, 1'b1};
    @(negedge ref_clk);
    {bit_op, ds_wr} = 2'b00;
  endtask
  // address held a cycle first: the window byte trails the address
  task automatic rd(logic [7:0] a, e, string n);
    @(negedge ref_clk);
    ds_addr = a;
    @(negedge ref_clk);
    ds_rd = 1'b1;
    @(negedge ref_clk);
    ds_rd = 1'b0;
    chk("rvalid", ds_rvalid, 8'h01);
    @(posedge ref_clk);
    #1 chk(n, ds_rdata, e);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    print_verdict;
  end
  initial begin
    void'($urandom(32'hB0AA));
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk) rst = 1'b0;
    wr(PAGE_SEL_ADDR, 8'h10, 1'b0);
    wr(PAGE_SEL_ADDR, 8'h08, 1'b1);
    chk("sel", ram_page_select, 8'h10);
    foreach (sv[i]) begin
      wr(PAGE_SEL_ADDR, sv[i], 1'b0);
      @(negedge ref_clk);
      chk("en", {bank0_en, page_one_en, page_two_en},
        {sv[i] == 0, sv[i] == 8'h08, sv[i] == 8'h10});
    end
    repeat (4) begin
      r = $urandom;
      k = $urandom % 64;
      wr(WIN_PAGE_ADDR, r | 8'h80, 1'b0);
      chk("page", rom_window_page, r[6:0]);
      rd(WIN_LO + k, pm({r[6:0], k[5:0]}), "rom");
      chk("paddr_hi", prog_addr[12:6], r[6:0]);
      chk("paddr_lo", prog_addr[5:0], k[5:0]);
    end
    k = $urandom % 64;
    foreach (sv[i]) begin
      wr(PAGE_SEL_ADDR, sv[i], 1'b0);
      wr(BANK_LO + k, sv[i] ^ 8'h5A, 1'b0);
    end
    foreach (sv[i]) begin
      wr(PAGE_SEL_ADDR, sv[i], 1'b0);
      rd(BANK_LO + k, sv[i] ^ 8'h5A, "bank");
    end
    wr(PAGE_SEL_ADDR, 8'h18, 1'b0);
    wr(BANK_LO + k, 8'hC3, 1'b0);
    wr(PAGE_SEL_ADDR, 8'h08, 1'b0);
    rd(BANK_LO + k, 8'hC3, "par1");
    wr(PAGE_SEL_ADDR, 8'h10, 1'b0);
    rd(BANK_LO + k, 8'hC3, "par2");
    wr(PAGE_SEL_ADDR, 8'h00, 1'b0);
    rd(BANK_LO + k, 8'h5A, "page0");
    rd(WIN_HI, pm({r[6:0], 6'h3F}), "rom");
    rd(WIN_PAGE_ADDR, 8'h00, "wo");
    chk("page", rom_window_page, r[6:0]);
    foreach (ra[i]) begin
      r = $urandom;
      wr(ra[i], r, 1'($urandom));
      rd(ra[i], r, "core");
    end
    print_verdict;
  end
endmodule
bind data_space_map data_space_map_chk data_space_map_chk_i (.*);

//--- bench/prog_mem_model.sv
// program memory stand-in: a byte computed from its address
module prog_mem_model (
  input wire logic [12:0] prog_addr, // window address
  output logic [7:0] prog_data // byte at that address
);
  timeunit 1ns;
  timeprecision 1ns;
  assign prog_data = prog_addr[7:0] ^ {3'h0, prog_addr[12:8]};
endmodule

//--- design/data_space_map.sv
// data-space decoder with ROM window, RAM page select and core registers
module data_space_map (
  input wire logic ref_clk, // core clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [7:0] ds_addr, // data-space address
  input wire logic ds_rd, // read strobe
  input wire logic ds_wr, // write strobe
  input wire logic [7:0] ds_wdata, // write data
  input wire logic bit_op, // access is a single-bit instruction
  output logic [7:0] ds_rdata, // read data, one cycle after ds_rd
  output logic ds_rvalid, // read data valid pulse
  output logic [7:0] accumulator_reg, // accumulator contents
  output logic [7:0] index_pointer_first, // first pointer
  output logic [7:0] index_pointer_second, // second pointer
  output logic [7:0] short_direct_first, // first short-direct
  output logic [7:0] short_direct_second, // second short-direct
  output logic [dspace_pkg::PROG_ADDR_W-1:0] prog_addr, // window address
  input wire logic [7:0] prog_data, // program memory byte, combinational
  output logic [6:0] rom_window_page, // window page bits
  output logic [7:0] ram_page_select, // page select contents
  output logic bank0_en, // bank region answered by page 0
  output logic page_one_en, // page 1 enabled
  output logic page_two_en // page 2 enabled
);
  import dspace_pkg::*;

  logic [7:0] page0_mem [0:63];
  logic [7:0] page1_mem [0:63];
  logic [7:0] page2_mem [0:63];
  logic [5:0] ofs;
  logic in_bank;
  logic in_win;
  logic sel_one;
  logic sel_two;
  logic [7:0] rdata_next;
  logic [7:0] bank_rd;
  logic acc_we;
  logic ptr1_we;
  logic ptr2_we;
  logic sd1_we;
  logic sd2_we;
  logic bank_we;
  logic none_sel;
  logic [7:0] page0_rd;
  logic [7:0] page1_rd;
  logic [7:0] page2_rd;

  function automatic logic hits(input logic we,
                                input logic [7:0] a,
                                input logic [7:0] target);
    hits = we && (a == target);
  endfunction

  function automatic logic in_range(input logic [7:0] a,
                                    input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  assign ofs = ds_addr[OFS_BITS-1:0];
  assign in_bank = in_range(ds_addr, BANK_LO, BANK_HI);
  assign in_win = in_range(ds_addr, WIN_LO, WIN_HI);
  assign sel_one = ram_page_select[PAGE_ONE_BIT];
  assign sel_two = ram_page_select[PAGE_TWO_BIT];
  assign none_sel = !sel_one && !sel_two;
  assign acc_we = hits(ds_wr, ds_addr, ACC_ADDR);
  assign ptr1_we = hits(ds_wr, ds_addr, PTR_FIRST_ADDR);
  assign ptr2_we = hits(ds_wr, ds_addr, PTR_SECOND_ADDR);
  assign sd1_we = hits(ds_wr, ds_addr, SD_FIRST_ADDR);
  assign sd2_we = hits(ds_wr, ds_addr, SD_SECOND_ADDR);
  assign bank_we = ds_wr && in_bank;
  assign page0_rd = page0_mem[ofs];
  assign page1_rd = page1_mem[ofs];
  assign page2_rd = page2_mem[ofs];

  // paging registers keep no reset: contents undefined until first write
  always_ff @(posedge ref_clk) begin
    if (ds_wr && !bit_op && ds_addr == WIN_PAGE_ADDR) begin
      rom_window_page <= ds_wdata[WIN_BITS-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (ds_wr && !bit_op && ds_addr == PAGE_SEL_ADDR) begin
      ram_page_select <= ds_wdata;
    end
  end

  // core registers; bit ops arrive as full read-modify-write bytes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      accumulator_reg <= CORE_RST;
    end else if (acc_we) begin
      accumulator_reg <= ds_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      index_pointer_first <= CORE_RST;
    end else if (ptr1_we) begin
      index_pointer_first <= ds_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      index_pointer_second <= CORE_RST;
    end else if (ptr2_we) begin
      index_pointer_second <= ds_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      short_direct_first <= CORE_RST;
    end else if (sd1_we) begin
      short_direct_first <= ds_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      short_direct_second <= CORE_RST;
    end else if (sd2_we) begin
      short_direct_second <= ds_wdata;
    end
  end

  // pages written in parallel when several bits are set
  always_ff @(posedge ref_clk) begin
    if (bank_we && none_sel) begin
      page0_mem[ofs] <= ds_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (bank_we && sel_one) begin
      page1_mem[ofs] <= ds_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (bank_we && sel_two) begin
      page2_mem[ofs] <= ds_wdata;
    end
  end

  // parallel pages fight on reads too; modelled as a wired-and
  always_comb begin
    bank_rd = 8'hFF;
    if (none_sel) begin
      bank_rd = page0_rd;
    end
    if (sel_one) begin
      bank_rd = bank_rd & page1_rd;
    end
    if (sel_two) begin
      bank_rd = bank_rd & page2_rd;
    end
  end

  always_comb begin
    rdata_next = 8'h00;
    if (in_bank) begin
      rdata_next = bank_rd;
    end else if (in_win) begin
      rdata_next = prog_data;
    end else begin
      case (ds_addr)
        ACC_ADDR: rdata_next = accumulator_reg;
        PTR_FIRST_ADDR: rdata_next = index_pointer_first;
        PTR_SECOND_ADDR: rdata_next = index_pointer_second;
        SD_FIRST_ADDR: rdata_next = short_direct_first;
        SD_SECOND_ADDR: rdata_next = short_direct_second;
        WIN_PAGE_ADDR: rdata_next = WRITE_ONLY_READ;
        PAGE_SEL_ADDR: rdata_next = WRITE_ONLY_READ;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // read data holds until the next read so a slow core can take it late
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ds_rdata <= CORE_RST;
    end else if (ds_rd) begin
      ds_rdata <= rdata_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ds_rvalid <= 1'b0;
    end else begin
      ds_rvalid <= ds_rd;
    end
  end

  // registered, so the window address trails ds_addr by one cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prog_addr <= '0;
    end else begin
      prog_addr <= {rom_window_page, ds_addr[OFS_BITS-1:0]};
    end
  end

  // enables trail the select register by one cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bank0_en <= 1'b0;
    end else begin
      bank0_en <= none_sel;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      page_one_en <= 1'b0;
    end else begin
      page_one_en <= sel_one;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      page_two_en <= 1'b0;
    end else begin
      page_two_en <= sel_two;
    end
  end
endmodule

//--- inc/dspace_pkg.sv
// constants for the data-space window and bank mapping block
// What this block does
// - window page register low seven bits used
// - window page unreset, write-only, no bit ops
// - select bit four maps RAM page two
// - select bit three maps RAM page one
// - bank page reached at addresses 00h-3Fh
// - several select bits enable pages together
// - page select not cleared by reset
// - page select untouched by calls, interrupts
// - page select write-only at CBh
// - accumulator mapped at FFh
// - pointer registers at 80h and 81h
// - short-direct registers at 82h and 83h
// - reads 40h-7Fh come from program memory
// - program address is page then six bits
package dspace_pkg;
  localparam logic [7:0] BANK_LO = 8'h00;
  localparam logic [7:0] BANK_HI = 8'h3F;
  localparam logic [7:0] WIN_LO = 8'h40;
  localparam logic [7:0] WIN_HI = 8'h7F;
  localparam logic [7:0] PTR_FIRST_ADDR = 8'h80;
  localparam logic [7:0] PTR_SECOND_ADDR = 8'h81;
  localparam logic [7:0] SD_FIRST_ADDR = 8'h82;
  localparam logic [7:0] SD_SECOND_ADDR = 8'h83;
  localparam logic [7:0] WIN_PAGE_ADDR = 8'hC9;
  localparam logic [7:0] PAGE_SEL_ADDR = 8'hCB;
  localparam logic [7:0] ACC_ADDR = 8'hFF;
  localparam int PAGE_TWO_BIT = 4;
  localparam int PAGE_ONE_BIT = 3;
  localparam int WIN_BITS = 7;
  localparam int OFS_BITS = 6;
  localparam int PROG_ADDR_W = WIN_BITS + OFS_BITS;
  localparam logic [7:0] WRITE_ONLY_READ = 8'h00;
  localparam logic [7:0] CORE_RST = 8'h00;
endpackage
